// ---- hw/i2c_slave_register_port.sv ----
// two-wire slave port giving a bus master access to the register bank
`timescale 1ns/10ps
`default_nettype none

// Contract
// (R1) act only as slave; seven-bit addressing only, other formats ignored
// (R2) answer only to fixed address 1101011
// (R3) start is data falling while clock high; detected by the port
// (R4) stop is data rising while clock high; release bus, await start
// (R5) transmitter keeps data stable while clock is high
// (R6) matching address acknowledged over whole ninth clock high phase
// (R7) every byte is eight bits plus acknowledge from the receiver
// (R8) master ends an abandoned transfer with a stop
// (R9) read of an unimplemented register returns FFh
// (R10) master code 00001XXX not acknowledged but switches to high speed
// (R11) after repeated start the byte protocol is unchanged, faster clock
// (R12) stop while in high speed returns to standard and fast operation
// (R13) master uses repeated starts to stay in high speed
// (R14) single write is start, address, register byte, data byte
// (R15) every received byte of a write is acknowledged
// (R16) data committed at clock fall ending its acknowledge
// (R17) further writes need only register byte and data byte pairs
// (R18) first byte after start is address, next is register address
// (R19) five eight-bit registers, four writable, one read-only
// (R20) standard, fast and high-speed rates supported
// (R21) direction bit zero means write, one means read
// (R22) read: register byte, repeated start with read, nack, stop
module i2c_slave_register_port #(
  parameter logic [6:0] OWN_ADDR = i2c_port_pkg::SLAVE_ADDR
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic [7:0] status_in,
  output i2c_port_pkg::cfg_s cfg,
  output i2c_port_pkg::reg_write_s reg_write,
  output logic hs_mode,
  output logic busy
);

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  logic scl_s;
  logic sda_s;
  logic scl_d_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  pin_sync #(.W(1), .IDLE_LEVEL(1'b1)) u_scl_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(scl_in),
    .sync_out(scl_s)
  );

  pin_sync #(.W(1), .IDLE_LEVEL(1'b1)) u_sda_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(sda_in),
    .sync_out(sda_s)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // sampling at 100 MHz leaves about 29 samples per bit at 3.4 Mbps
  assign scl_rise = scl_s && !scl_d_reg; // R20
  assign scl_fall = !scl_s && scl_d_reg;
  assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s; // R3
  assign stop_det = scl_s && scl_d_reg && !sda_d_reg && sda_s; // R4

  // ----------------------------------------
  // protocol state
  // ----------------------------------------
  i2c_port_pkg::port_state_e state_reg;
  i2c_port_pkg::byte_role_e role_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic read_reg;
  logic nack_reg;
  logic hs_reg;
  logic drive_low;
  logic oe_n_reg;
  logic [7:0] rd_data;
  logic byte_done;
  logic addr_hit;
  logic hs_code;
  logic ack_end;
  logic commit;
  logic load_first;
  logic load_next;

  assign byte_done = (state_reg == i2c_port_pkg::ST_RECV) && scl_fall
                     && (bit_cnt_reg == i2c_port_pkg::BYTE_BITS); // R7
  // the address compare uses the top seven bits only: no extended format
  assign addr_hit = (shift_reg[7:1] == OWN_ADDR); // R1 R2
  assign hs_code = (shift_reg[7:3] == i2c_port_pkg::HS_CODE_TOP); // R10
  assign ack_end = (state_reg == i2c_port_pkg::ST_ACK) && scl_fall;
  assign commit = ack_end && (role_reg == i2c_port_pkg::ROLE_DATA); // R16
  assign load_first = ack_end && read_reg
                      && (role_reg == i2c_port_pkg::ROLE_ADDR);
  assign load_next = (state_reg == i2c_port_pkg::ST_RACK) && scl_fall
                     && !nack_reg;

  // ----------------------------------------
  // transfer sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= i2c_port_pkg::ST_IDLE;
      role_reg <= i2c_port_pkg::ROLE_ADDR;
      bit_cnt_reg <= '0;
      read_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= i2c_port_pkg::ST_IDLE; // R4 R8
      role_reg <= i2c_port_pkg::ROLE_ADDR;
      bit_cnt_reg <= '0;
      read_reg <= 1'b0;
    end else if (start_det) begin
      // a repeated start also lands here and restarts address framing
      state_reg <= i2c_port_pkg::ST_RECV; // R3 R11 R18
      role_reg <= i2c_port_pkg::ROLE_ADDR;
      bit_cnt_reg <= '0;
      read_reg <= 1'b0;
    end else begin
      case (state_reg)
        i2c_port_pkg::ST_IDLE: begin
          bit_cnt_reg <= '0;
        end
        i2c_port_pkg::ST_RECV: begin
          if (scl_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          if (byte_done) begin
            bit_cnt_reg <= '0;
            if (role_reg != i2c_port_pkg::ROLE_ADDR) begin
              state_reg <= i2c_port_pkg::ST_ACK; // R15
            end else if (addr_hit) begin
              state_reg <= i2c_port_pkg::ST_ACK; // R6
              read_reg <= shift_reg[0]; // R21
            end else begin
              // foreign address or master code: stay off the bus
              state_reg <= i2c_port_pkg::ST_IDLE; // R6 R10
            end
          end
        end
        i2c_port_pkg::ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= '0;
            if (read_reg) begin
              state_reg <= i2c_port_pkg::ST_SEND; // R22
            end else begin
              state_reg <= i2c_port_pkg::ST_RECV;
              case (role_reg)
                i2c_port_pkg::ROLE_ADDR: role_reg <= i2c_port_pkg::ROLE_REG; // R18
                i2c_port_pkg::ROLE_REG: role_reg <= i2c_port_pkg::ROLE_DATA; // R14
                i2c_port_pkg::ROLE_DATA: role_reg <= i2c_port_pkg::ROLE_REG; // R17
                default: role_reg <= i2c_port_pkg::ROLE_ADDR;
              endcase
            end
          end
        end
        i2c_port_pkg::ST_SEND: begin
          if (scl_fall) begin
            if (bit_cnt_reg == i2c_port_pkg::TX_LAST_BIT) begin
              bit_cnt_reg <= '0;
              state_reg <= i2c_port_pkg::ST_RACK; // R7
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        i2c_port_pkg::ST_RACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= '0;
            if (nack_reg) begin
              // master is done reading; only a stop or start moves us
              state_reg <= i2c_port_pkg::ST_IDLE; // R22
            end else begin
              state_reg <= i2c_port_pkg::ST_SEND;
            end
          end
        end
        default: begin
          state_reg <= i2c_port_pkg::ST_IDLE;
          bit_cnt_reg <= '0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // receive shifter
  // ----------------------------------------
  // sampled on the rising clock edge, where the master holds data stable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      shift_reg <= '0;
    end else if (state_reg == i2c_port_pkg::ST_RECV && scl_rise) begin
      shift_reg <= {shift_reg[6:0], sda_s}; // R5
    end
  end

  // ----------------------------------------
  // master acknowledge capture
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nack_reg <= 1'b1;
    end else if (state_reg == i2c_port_pkg::ST_RACK && scl_rise) begin
      nack_reg <= sda_s; // R22
    end
  end

  // ----------------------------------------
  // register pointer
  // ----------------------------------------
  // stepping on the master's ack rise gives the read port time to settle
  // before the next byte is loaded on the following fall
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ptr_reg <= '0;
    end else if (ack_end && role_reg == i2c_port_pkg::ROLE_REG) begin
      ptr_reg <= shift_reg; // R18
    end else if (state_reg == i2c_port_pkg::ST_RACK && scl_rise && !sda_s) begin
      ptr_reg <= ptr_reg + i2c_port_pkg::PTR_STEP;
    end
  end

  // ----------------------------------------
  // transmit shifter
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_reg <= i2c_port_pkg::UNMAPPED_VALUE;
    end else if (load_first || load_next) begin
      tx_reg <= rd_data; // R9
    end else if (state_reg == i2c_port_pkg::ST_SEND && scl_fall) begin
      tx_reg <= {tx_reg[6:0], 1'b1};
    end
  end

  // ----------------------------------------
  // high-speed mode
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hs_reg <= 1'b0;
    end else if (stop_det) begin
      hs_reg <= 1'b0; // R12
    end else if (byte_done && role_reg == i2c_port_pkg::ROLE_ADDR && hs_code) begin
      hs_reg <= 1'b1; // R10
    end
  end

  // ----------------------------------------
  // data pin drive
  // ----------------------------------------
  // open drain: the pin is only ever pulled low, never driven high
  always_comb begin
    drive_low = 1'b0;
    case (state_reg)
      i2c_port_pkg::ST_ACK: drive_low = 1'b1; // R6 R15
      i2c_port_pkg::ST_SEND: drive_low = !tx_reg[7]; // R7
      default: drive_low = 1'b0;
    endcase
  end

  // one cycle of register delay keeps the hold time after the clock fall
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      oe_n_reg <= 1'b1;
    end else if (stop_det || start_det) begin
      oe_n_reg <= 1'b1; // R4
    end else begin
      oe_n_reg <= !drive_low;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_n = oe_n_reg;

  // ----------------------------------------
  // registered write strobe on the reg_write output
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_write <= '0;
    end else begin
      reg_write.strobe <= commit; // R16
      if (commit) begin
        reg_write.addr <= ptr_reg;
        reg_write.data <= shift_reg;
      end
    end
  end

  // ----------------------------------------
  // register bank
  // ----------------------------------------
  reg_bank #(
    .N(i2c_port_pkg::REG_COUNT),
    .W(i2c_port_pkg::DATA_W),
    .RESET_VAL(i2c_port_pkg::CFG_RESET)
  ) u_bank (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(commit), // R16 R19
    .wr_addr(ptr_reg),
    .wr_data(shift_reg),
    .rd_addr(ptr_reg),
    .ro_value(status_in),
    .rd_data(rd_data),
    .cfg_out(cfg)
  );

  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hs_mode <= 1'b0;
      busy <= 1'b0;
    end else begin
      hs_mode <= hs_reg;
      busy <= (state_reg != i2c_port_pkg::ST_IDLE);
    end
  end

endmodule : i2c_slave_register_port
`default_nettype wire

// ---- hw/pin_sync.sv ----
// two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] IDLE_LEVEL = '1
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [W-1:0] pin_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_reg;

  // the bus idles high, so reset to the released level
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_reg <= IDLE_LEVEL;
      sync_out <= IDLE_LEVEL;
    end else begin
      meta_reg <= pin_in;
      sync_out <= meta_reg;
    end
  end
endmodule : pin_sync
`default_nettype wire

// ---- hw/reg_bank.sv ----
// small register bank: one read-only slot, the rest writable
`timescale 1ns/10ps
`default_nettype none
module reg_bank #(
  parameter int N = i2c_port_pkg::REG_COUNT,
  parameter int W = i2c_port_pkg::DATA_W,
  parameter logic [(N-1)*W-1:0] RESET_VAL = i2c_port_pkg::CFG_RESET
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  input wire logic [7:0] rd_addr,
  input wire logic [W-1:0] ro_value,
  output logic [W-1:0] rd_data,
  output logic [(N-1)*W-1:0] cfg_out
);
  // ----------------------------------------
  // writable storage
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_out <= RESET_VAL;
    end else begin
      for (int i = 1; i < N; i++) begin
        if (wr_en && wr_addr == 8'(i)) begin
          cfg_out[(i-1)*W +: W] <= wr_data;
        end
      end
    end
  end

  // ----------------------------------------
  // registered read port
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rd_data <= i2c_port_pkg::UNMAPPED_VALUE;
    end else if (rd_addr == i2c_port_pkg::RO_INDEX) begin
      rd_data <= ro_value;
    end else if (rd_addr < 8'(N)) begin
      rd_data <= cfg_out[(32'(rd_addr)-1)*W +: W];
    end else begin
      rd_data <= i2c_port_pkg::UNMAPPED_VALUE; // R9
    end
  end
endmodule : reg_bank
`default_nettype wire

// ---- include/i2c_port_pkg.sv ----
// shared constants, encodings and carriers of the two-wire register port
package i2c_port_pkg;

  // ----------------------------------------
  // bus identity and byte framing
  // ----------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h6B;
  localparam logic [4:0] HS_CODE_TOP = 5'h01;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] TX_LAST_BIT = 4'h7;

  // ----------------------------------------
  // register space
  // ----------------------------------------
  localparam int REG_COUNT = 5;
  localparam int DATA_W = 8;
  localparam logic [7:0] RO_INDEX = 8'h00;
  localparam logic [7:0] UNMAPPED_VALUE = 8'hFF;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [7:0] PTR_STEP = 8'h01;

  // ----------------------------------------
  // protocol states and byte roles
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b0_0001,
    ST_RECV = 5'b0_0010,
    ST_ACK  = 5'b0_0100,
    ST_SEND = 5'b0_1000,
    ST_RACK = 5'b1_0000
  } port_state_e;

  typedef enum logic [2:0] {
    ROLE_ADDR = 3'b001,
    ROLE_REG  = 3'b010,
    ROLE_DATA = 3'b100
  } byte_role_e;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] cfg4;
    logic [7:0] cfg3;
    logic [7:0] cfg2;
    logic [7:0] cfg1;
  } cfg_s;

  typedef struct packed {
    logic strobe;
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_s;

endpackage : i2c_port_pkg

// ---- test/i2c_master_model.sv ----
// bus master model: drives the clock pin and pulls the data line
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
  input wire logic ref_clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_oe_n
);
  // half clock period in ref_clk cycles; 125 gives 400 kHz
  int half = 125;
  initial begin
    scl = 1'b1;
    sda_oe_n = 1'b1;
  end
  task automatic hw();
    repeat (half) @(negedge ref_clk);
  endtask : hw
  // also serves as repeated start when the clock is low
  task automatic start();
    sda_oe_n = 1'b1;
    hw();
    scl = 1'b1;
    hw();
    sda_oe_n = 1'b0;
    hw();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    sda_oe_n = 1'b0;
    hw();
    scl = 1'b1;
    hw();
    sda_oe_n = 1'b1;
    repeat (3) hw();
  endtask : stop
  task automatic xbit(input logic v, output logic s);
    sda_oe_n = v;
    hw();
    scl = 1'b1;
    hw();
    s = sda_wire;
    scl = 1'b0;
  endtask : xbit
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) xbit(b[i], s);
    xbit(1'b1, s);
    ack = ~s;
  endtask : put_byte
  task automatic get_byte(input logic mack, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) xbit(1'b1, b[i]);
    xbit(~mack, s);
  endtask : get_byte
endmodule : i2c_master_model
`default_nettype wire

// ---- test/i2c_port_props.sv ----
// concurrent checks on the pins of the two-wire register port
`timescale 1ns/10ps
`default_nettype none
module i2c_port_props (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic [7:0] status_in,
  input wire i2c_port_pkg::cfg_s cfg,
  input wire i2c_port_pkg::reg_write_s reg_write,
  input wire logic hs_mode,
  input wire logic busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  pull_only_a: assert property (sda_out == 1'b0)
    else $error("data pin value is not a pull-down");
  oe_clock_low_a: assert property (!$stable(sda_oe_n) |-> !scl_in)
    else $error("data pin changed while clock high");
  pull_length_a: assert property ($fell(sda_oe_n) |-> !sda_oe_n [*8])
    else $error("data pull too short for a clock high phase");
  cfg_strobe_a: assert property (!$stable(cfg) |-> reg_write.strobe)
    else $error("register changed without write strobe");
  strobe_once_a: assert property (reg_write.strobe |=> !reg_write.strobe)
    else $error("write strobe longer than one cycle");
  commit_low_a: assert property (reg_write.strobe |-> !scl_in && !$past(scl_in, 2))
    else $error("commit not after acknowledge clock fall");
  hs_exit_a: assert property ($fell(hs_mode) |-> scl_in && sda_in && $past(scl_in, 3))
    else $error("high speed left without a stop");
  hs_noack_a: assert property ($rose(hs_mode) |-> sda_oe_n && !busy)
    else $error("master code was acknowledged");
endmodule : i2c_port_props

bind i2c_slave_register_port i2c_port_props props_u (.ref_clk(ref_clk), .rst(rst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
  .status_in(status_in), .cfg(cfg), .reg_write(reg_write), .hs_mode(hs_mode),
  .busy(busy));
`default_nettype wire

// ---- test/i2c_slave_register_port_tb.sv ----
// self-checking bench for the two-wire register port
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
module i2c_slave_register_port_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] status_in = 8'h5A;
  logic scl, m_oe_n, sda_out, sda_oe_n, hs_mode, busy, ack;
  logic [7:0] rb;
  wire logic sda_wire;
  i2c_port_pkg::cfg_s cfg;
  i2c_port_pkg::reg_write_s reg_write;
  int err_count = 0;
  int cmp_count = 0;
  logic [7:0] wv [5] = '{8'h77, 8'h1F, 8'h2E, 8'h3D, 8'h4C};
  logic [7:0] rv [6] = '{8'hC3, 8'h1F, 8'h2E, 8'h3D, 8'h4C, 8'hFF};
  // open drain: any pull wins, pull-up otherwise
  assign sda_wire = m_oe_n & (sda_oe_n | sda_out);
  initial forever #5 ref_clk = ~ref_clk;
  i2c_slave_register_port dut_u (.ref_clk(ref_clk), .rst(rst), .scl_in(scl),
    .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .status_in(status_in),
    .cfg(cfg), .reg_write(reg_write), .hs_mode(hs_mode), .busy(busy));
  i2c_master_model m_u (.ref_clk(ref_clk), .sda_wire(sda_wire), .scl(scl),
    .sda_oe_n(m_oe_n));
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  task automatic send_chk(input logic [7:0] b, input logic exp);
    m_u.put_byte(b, ack);
    `CHK("ack", exp, ack)
  endtask : send_chk
  task automatic t_reset();
    `CHK("cfg", 32'h0000_0000, cfg)
    `CHK("oe_n", 1'b1, sda_oe_n)
    `CHK("busy", 1'b0, busy)
    $display("test reset done");
  endtask : t_reset
  task automatic t_write();
    m_u.start();
    send_chk(8'hD6, 1'b1);
    for (int i = 0; i < 5; i++) begin
      send_chk(i[7:0], 1'b1);
      send_chk(wv[i], 1'b1);
    end
    m_u.stop();
    `CHK("cfg", 32'h4C3D_2E1F, cfg)
    `CHK("wr_addr", 8'h04, reg_write.addr)
    `CHK("wr_data", 8'h4C, reg_write.data)
    $display("test write done");
  endtask : t_write
  task automatic t_read();
    // a fresh status value shows that the read-only slot follows its input
    status_in = 8'hC3;
    m_u.start();
    send_chk(8'hD6, 1'b1);
    send_chk(8'h00, 1'b1);
    m_u.start();
    send_chk(8'hD7, 1'b1);
    for (int i = 0; i < 6; i++) begin
      m_u.get_byte(i < 5, rb);
      `CHK("rdata", rv[i], rb)
    end
    m_u.stop();
    $display("test read done");
  endtask : t_read
  task automatic t_foreign();
    logic [7:0] bad [3] = '{8'hD4, 8'hF0, 8'h00};
    foreach (bad[i]) begin
      m_u.start();
      send_chk(bad[i], 1'b0);
      m_u.stop();
    end
    `CHK("cfg", 32'h4C3D_2E1F, cfg)
    $display("test foreign done");
  endtask : t_foreign
  task automatic t_hs();
    for (int i = 0; i < 8; i++) begin
      m_u.start();
      send_chk(8'h08 | i[7:0], 1'b0);
      repeat (8) @(negedge ref_clk);
      `CHK("hs", 1'b1, hs_mode)
      if (i == 7) begin
        m_u.half = 15;
        m_u.start();
        send_chk(8'hD6, 1'b1);
        send_chk(8'h02, 1'b1);
        send_chk(8'h5E, 1'b1);
        `CHK("hs", 1'b1, hs_mode)
      end
      m_u.stop();
      m_u.half = 125;
      `CHK("hs", 1'b0, hs_mode)
    end
    `CHK("cfg", 32'h4C3D_5E1F, cfg)
    $display("test high speed done");
  endtask : t_hs
  task automatic t_abort();
    m_u.start();
    for (int i = 0; i < 4; i++) m_u.xbit(1'b1, ack);
    `CHK("busy", 1'b1, busy)
    m_u.stop();
    `CHK("busy", 1'b0, busy)
    m_u.start();
    send_chk(8'hD6, 1'b1);
    send_chk(8'h03, 1'b1);
    send_chk(8'h99, 1'b1);
    m_u.stop();
    `CHK("cfg3", 8'h99, cfg.cfg3)
    $display("test abort done");
  endtask : t_abort
  initial begin
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    repeat (5) @(negedge ref_clk);
    t_reset();
    t_write();
    t_read();
    t_foreign();
    t_hs();
    t_abort();
    summarize();
  end
  // hang guard
  initial begin
    repeat (99000) @(posedge ref_clk);
    err_count++;
    summarize();
  end
endmodule : i2c_slave_register_port_tb
`default_nettype wire
